// [dse_pkg.sv]
// constants and types of the syndrome encoder
// shared by the top module and its leaves
package dse_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_SYND = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0c;

    // syndrome field layout
    localparam int SYND_WALK_POS = 7;
    localparam int SYND_DIR_POS = 6;
    localparam int FSC_W = 6;

    // control field layout
    localparam int CTRL_EXT_ADDR_POS = 0;
    localparam int CTRL_MEM_TAG_POS = 1;
    localparam int CTRL_RELIAB_POS = 2;
    localparam int CTRL_GRANULE_POS = 3;
    localparam int CTRL_HW_AD_POS = 4;
    localparam int CTRL_RELAX_POS = 5;
    localparam int CTRL_W = 6;

    // status field layout
    localparam int STAT_VALID_POS = 0;
    localparam int STAT_REJECT_POS = 1;

    // reset values
    localparam logic [7:0] SYND_RST = 8'h00;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // lookup levels -1 and 3 on the level input
    localparam logic [2:0] LVL_M1 = 3'h7;
    localparam logic [2:0] LVL_3 = 3'h3;

    // fault status codes
    localparam logic [5:0] FSC_ADDR_SIZE = 6'h00;
    localparam logic [5:0] FSC_ADDR_SIZE_M1 = 6'h29;
    localparam logic [5:0] FSC_TRANS = 6'h04;
    localparam logic [5:0] FSC_TRANS_M1 = 6'h2b;
    localparam logic [5:0] FSC_ACC_FLAG = 6'h08;
    localparam logic [5:0] FSC_PERM = 6'h0c;
    localparam logic [5:0] FSC_EXT = 6'h10;
    localparam logic [5:0] FSC_TAG = 6'h11;
    localparam logic [5:0] FSC_EXT_WALK_M1 = 6'h13;
    localparam logic [5:0] FSC_EXT_WALK = 6'h14;
    localparam logic [5:0] FSC_PAR = 6'h18;
    localparam logic [5:0] FSC_PAR_WALK_M1 = 6'h1b;
    localparam logic [5:0] FSC_PAR_WALK = 6'h1c;
    localparam logic [5:0] FSC_ALIGN = 6'h21;
    localparam logic [5:0] FSC_GPF_WALK_M1 = 6'h23;
    localparam logic [5:0] FSC_GPF_WALK = 6'h24;
    localparam logic [5:0] FSC_GPF = 6'h28;
    localparam logic [5:0] FSC_TLB_CONFLICT = 6'h30;
    localparam logic [5:0] FSC_UNS_HW_UPD = 6'h31;
    localparam logic [5:0] FSC_LOCKDOWN = 6'h34;
    localparam logic [5:0] FSC_UNS_EXCL = 6'h35;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        F_ADDR_SIZE = 4'b0000,
        F_TRANS = 4'b0001,
        F_ACC_FLAG = 4'b0010,
        F_PERM = 4'b0011,
        F_EXT = 4'b0100,
        F_PARITY = 4'b0101,
        F_TAG = 4'b0110,
        F_GPF = 4'b0111,
        F_ALIGN = 4'b1000,
        F_TLB_CONFLICT = 4'b1001,
        F_LOCKDOWN = 4'b1010,
        F_UNS_HW_UPD = 4'b1011,
        F_UNS_EXCL = 4'b1100
    } dse_fault_e;

endpackage

// [dse_rb_if.sv]
// register strobes between axi leaves and register file
// all in the clk domain
`timescale 1ns/1ps
interface dse_rb_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport wr (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_err);
    modport rd (output rd_addr, input rd_data, input rd_err);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_err,
                  input rd_addr, output rd_data, output rd_err);
endinterface

// [dse_axil_wr.sv]
// axi4-lite write channels: address and data taken in either order
// assumes wr_err is combinational
`timescale 1ns/1ps
module dse_axil_wr (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    dse_rb_if.wr rb // register strobes
);
    logic aw_have_r, aw_have_nxt;
    logic w_have_r, w_have_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    logic [3:0] strb_r, strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic do_wr;

    // fires once both halves held
    assign do_wr = aw_have_r && w_have_r && !bvalid_r;
    assign rb.wr_en = do_wr;
    assign rb.wr_addr = addr_r;
    assign rb.wr_data = data_r;
    assign rb.wr_strb = strb_r;
    assign awready = !aw_have_r;
    assign wready = !w_have_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        strb_nxt = strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            addr_nxt = awaddr;
        end
        if (wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            data_nxt = wdata;
            strb_nxt = wstrb;
        end
        if (do_wr) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = rb.wr_err ? dse_pkg::RESP_SLVERR : dse_pkg::RESP_OKAY;
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            addr_r <= 8'h00;
            data_r <= 32'h0000_0000;
            strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            strb_r <= strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end
endmodule

// [dse_axil_rd.sv]
// axi4-lite read channels: one read at a time, data registered
// assumes rd_data and rd_err are combinational
`timescale 1ns/1ps
module dse_axil_rd (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    dse_rb_if.rd rb // register read port
);
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    assign rb.rd_addr = araddr;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end else if (!rvalid_r && arvalid) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rb.rd_data;
            rresp_nxt = rb.rd_err ? dse_pkg::RESP_SLVERR : dse_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
endmodule

// [dse_syndrome.sv]
// data abort syndrome encoder: captures walk bit, direction bit and fault code
// assumes a one-cycle take pulse with its fault attributes
// Function
// - stage 2 fault on stage 1 walk access sets walk bit to one
// - walk bit reads zero for every abort that is not stage 2
// - direction bit is zero for reads and one for writes
// - cache maintenance or address translation faults report direction one
// - atomic: direction zero if a read would fault, else one
// - optional: stage 2 walk aborts for atomics may report direction zero
// - direction may be unknown for atomic external aborts and unsupported codes
// - address size faults coded by level, level -1 with extended addressing
// - translation faults coded by level, level -1 with extended addressing
// - access flag faults levels 1 to 3, level 0 with extended addressing
// - permission faults levels 1 to 3, level 0 with extended addressing
// - external abort off walk reports its single code
// - external abort on walk coded by level, level -1 extended addressing
// - parity or ecc codes only without the reliability extension
// - tag check fault code only with memory tagging
// - granule protection codes only with granule protection option
// - alignment, tlb conflict and lockdown have fixed codes
// - unsupported hardware update and unsupported exclusive have fixed codes
// - reserved fault codes are never produced
// - with walk bit set the level is the stage 2 level
// - after warm reset the syndrome fields hold no defined value; reset here loads SYND_RST, all zero
`timescale 1ns/1ps
module dse_syndrome (
    input wire logic clk, // core clock, 25 mhz
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic abort_take, // data abort taken this cycle
    input wire logic [3:0] abort_class, // fault class
    input wire logic abort_on_walk, // fault on table walk or table update
    input wire logic [2:0] abort_level, // lookup level, 3'h7 is level -1
    input wire logic abort_stage2, // fault came from stage 2
    input wire logic abort_s1_walk, // access was made for a stage 1 walk
    input wire logic abort_write, // instruction was writing
    input wire logic abort_maint, // cache maintenance or address translation
    input wire logic abort_atomic, // atomic read-modify-write
    input wire logic abort_atomic_rd_fault, // a read would have faulted
    output logic walk_origin_bit, // captured walk bit
    output logic access_direction_bit, // captured direction bit
    output logic [5:0] fault_status_code, // captured fault code
    output logic syndrome_valid, // a syndrome has been captured
    output logic encode_reject // attributes had no legal code
);
    dse_rb_if rb ();

    logic [7:0] synd_r, synd_nxt;
    logic [5:0] ctrl_r, ctrl_nxt;
    logic valid_r, valid_nxt;
    logic reject_r, reject_nxt;
    logic reject_pulse_r, reject_pulse_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [6:0] enc;
    logic enc_ok;
    logic walk_b;
    logic dir_b;
    logic stat_clr_valid;
    logic stat_clr_reject;

    dse_axil_wr u_wr (
        .clk(clk),
        .resetn(resetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .rb(rb.wr)
    );

    dse_axil_rd u_rd (
        .clk(clk),
        .resetn(resetn),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb.rd)
    );

    // offset decode shared by reads and writes
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = reg_hit(a, dse_pkg::OFS_SYND) || reg_hit(a, dse_pkg::OFS_CTRL) ||
                     reg_hit(a, dse_pkg::OFS_STAT) || reg_hit(a, dse_pkg::OFS_CNT);
    endfunction

    // returns {legal, code}
    function automatic logic [6:0] fsc_encode(input logic [3:0] cls, input logic walk,
                                              input logic [2:0] lvl, input logic [5:0] opt);
        logic ext_a;
        logic m1;
        logic l0;
        logic lv_ok;
        logic [5:0] l6;
        logic ok;
        logic [5:0] c;
        ext_a = opt[dse_pkg::CTRL_EXT_ADDR_POS];
        m1 = (lvl == dse_pkg::LVL_M1);
        l0 = (lvl == 3'h0);
        lv_ok = (lvl <= dse_pkg::LVL_3);
        l6 = {4'h0, lvl[1:0]};
        ok = 1'b0;
        c = 6'h00;
        case (cls)
            dse_pkg::F_ADDR_SIZE: begin
                ok = lv_ok || (m1 && ext_a);
                c = m1 ? dse_pkg::FSC_ADDR_SIZE_M1 : dse_pkg::FSC_ADDR_SIZE + l6;
            end
            dse_pkg::F_TRANS: begin
                ok = lv_ok || (m1 && ext_a);
                c = m1 ? dse_pkg::FSC_TRANS_M1 : dse_pkg::FSC_TRANS + l6;
            end
            dse_pkg::F_ACC_FLAG: begin
                ok = lv_ok && (!l0 || ext_a);
                c = dse_pkg::FSC_ACC_FLAG + l6;
            end
            dse_pkg::F_PERM: begin
                ok = lv_ok && (!l0 || ext_a);
                c = dse_pkg::FSC_PERM + l6;
            end
            dse_pkg::F_EXT: begin
                if (!walk) begin
                    ok = 1'b1;
                    c = dse_pkg::FSC_EXT;
                end else begin
                    ok = lv_ok || (m1 && ext_a);
                    c = m1 ? dse_pkg::FSC_EXT_WALK_M1 : dse_pkg::FSC_EXT_WALK + l6;
                end
            end
            dse_pkg::F_PARITY: begin
                if (!walk) begin
                    ok = !opt[dse_pkg::CTRL_RELIAB_POS];
                    c = dse_pkg::FSC_PAR;
                end else begin
                    ok = !opt[dse_pkg::CTRL_RELIAB_POS] && (lv_ok || (m1 && ext_a));
                    c = m1 ? dse_pkg::FSC_PAR_WALK_M1 : dse_pkg::FSC_PAR_WALK + l6;
                end
            end
            dse_pkg::F_TAG: begin
                ok = opt[dse_pkg::CTRL_MEM_TAG_POS];
                c = dse_pkg::FSC_TAG;
            end
            dse_pkg::F_GPF: begin
                if (!walk) begin
                    ok = opt[dse_pkg::CTRL_GRANULE_POS];
                    c = dse_pkg::FSC_GPF;
                end else begin
                    ok = opt[dse_pkg::CTRL_GRANULE_POS] && (lv_ok || (m1 && ext_a));
                    c = m1 ? dse_pkg::FSC_GPF_WALK_M1 : dse_pkg::FSC_GPF_WALK + l6;
                end
            end
            dse_pkg::F_ALIGN: begin
                ok = 1'b1;
                c = dse_pkg::FSC_ALIGN;
            end
            dse_pkg::F_TLB_CONFLICT: begin
                ok = 1'b1;
                c = dse_pkg::FSC_TLB_CONFLICT;
            end
            dse_pkg::F_LOCKDOWN: begin
                ok = 1'b1;
                c = dse_pkg::FSC_LOCKDOWN;
            end
            dse_pkg::F_UNS_HW_UPD: begin
                ok = opt[dse_pkg::CTRL_HW_AD_POS];
                c = dse_pkg::FSC_UNS_HW_UPD;
            end
            dse_pkg::F_UNS_EXCL: begin
                ok = 1'b1;
                c = dse_pkg::FSC_UNS_EXCL;
            end
            default: begin
                ok = 1'b0;
                c = 6'h00;
            end
        endcase
        fsc_encode = {ok, c};
    endfunction

    // level is the stage 2 level on walks
    assign enc = fsc_encode(abort_class, abort_on_walk, abort_level, ctrl_r);
    assign enc_ok = enc[6];

    // walk bit only for stage 2 faults
    assign walk_b = abort_stage2 && abort_s1_walk;

    always_comb begin
        dir_b = abort_write;
        if (abort_maint) begin
            dir_b = 1'b1;
        end else if (abort_atomic) begin
            // atomic external aborts take the same defined value
            if (ctrl_r[dse_pkg::CTRL_RELAX_POS] && walk_b) begin
                dir_b = 1'b0;
            end else begin
                dir_b = !abort_atomic_rd_fault;
            end
        end
    end

    // status clears: write one to clear, a new event wins
    assign stat_clr_valid = rb.wr_en && reg_hit(rb.wr_addr, dse_pkg::OFS_STAT) &&
                            rb.wr_strb[0] && rb.wr_data[dse_pkg::STAT_VALID_POS];
    assign stat_clr_reject = rb.wr_en && reg_hit(rb.wr_addr, dse_pkg::OFS_STAT) &&
                             rb.wr_strb[0] && rb.wr_data[dse_pkg::STAT_REJECT_POS];

    assign rb.wr_err = !reg_mapped(rb.wr_addr);
    assign rb.rd_err = !reg_mapped(rb.rd_addr);

    always_comb begin
        rb.rd_data = 32'h0000_0000;
        if (reg_hit(rb.rd_addr, dse_pkg::OFS_SYND)) begin
            rb.rd_data = {24'h00_0000, synd_r};
        end else if (reg_hit(rb.rd_addr, dse_pkg::OFS_CTRL)) begin
            rb.rd_data = {26'h000_0000, ctrl_r};
        end else if (reg_hit(rb.rd_addr, dse_pkg::OFS_STAT)) begin
            rb.rd_data = {30'h0000_0000, reject_r, valid_r};
        end else if (reg_hit(rb.rd_addr, dse_pkg::OFS_CNT)) begin
            rb.rd_data = {16'h0000, cnt_r};
        end
    end

    always_comb begin
        synd_nxt = synd_r;
        ctrl_nxt = ctrl_r;
        valid_nxt = valid_r;
        reject_nxt = reject_r;
        reject_pulse_nxt = 1'b0;
        cnt_nxt = cnt_r;
        if (rb.wr_en && reg_hit(rb.wr_addr, dse_pkg::OFS_CTRL) && rb.wr_strb[0]) begin
            ctrl_nxt = rb.wr_data[dse_pkg::CTRL_W-1:0];
        end
        if (stat_clr_valid) begin
            valid_nxt = 1'b0;
        end
        if (stat_clr_reject) begin
            reject_nxt = 1'b0;
        end
        if (abort_take) begin
            if (enc_ok) begin
                synd_nxt = {walk_b, dir_b, enc[dse_pkg::FSC_W-1:0]};
                valid_nxt = 1'b1;
                cnt_nxt = cnt_r + 16'h0001;
            end else begin
                // reserved code withheld, old syndrome kept
                reject_nxt = 1'b1;
                reject_pulse_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // reset value is arbitrary for software
            synd_r <= dse_pkg::SYND_RST;
            ctrl_r <= dse_pkg::CTRL_RST;
            valid_r <= 1'b0;
            reject_r <= 1'b0;
            reject_pulse_r <= 1'b0;
            cnt_r <= dse_pkg::CNT_RST;
        end else begin
            synd_r <= synd_nxt;
            ctrl_r <= ctrl_nxt;
            valid_r <= valid_nxt;
            reject_r <= reject_nxt;
            reject_pulse_r <= reject_pulse_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign walk_origin_bit = synd_r[dse_pkg::SYND_WALK_POS];
    assign access_direction_bit = synd_r[dse_pkg::SYND_DIR_POS];
    assign fault_status_code = synd_r[dse_pkg::FSC_W-1:0];
    assign syndrome_valid = valid_r;
    assign encode_reject = reject_pulse_r;
endmodule

// [dse_syndrome_checker.sv]
// syndrome capture assertions
// bound into dse_syndrome
`timescale 1ns/1ps
module dse_syndrome_checker (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, low
    input wire logic abort_take, // abort taken
    input wire logic [3:0] abort_class, // fault class
    input wire logic [2:0] abort_level, // lookup level
    input wire logic abort_stage2, // stage 2 fault
    input wire logic abort_s1_walk, // stage 1 walk access
    input wire logic abort_write, // writing
    input wire logic abort_maint, // maintenance
    input wire logic abort_atomic, // atomic
    input wire logic abort_atomic_rd_fault, // read faults
    input wire logic walk_origin_bit, // walk bit
    input wire logic access_direction_bit, // direction bit
    input wire logic [5:0] fault_status_code, // fault code
    input wire logic encode_reject // reject pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire lv = abort_level < 3'h4;
    wire tr = abort_take && abort_class == 4'h1 && lv;
    wire [7:0] syn = {walk_origin_bit, access_direction_bit, fault_status_code};
    a_walk_bit: assert property (tr |=> walk_origin_bit == ($past(abort_stage2) && $past(abort_s1_walk)))
        else $error("walk bit wrong");
    a_trans_code: assert property (tr |=> fault_status_code == 6'h04 + $past(abort_level))
        else $error("trans code wrong");
    a_dir_maint: assert property (tr && abort_maint |=> access_direction_bit)
        else $error("maint dir wrong");
    a_dir_write: assert property (tr && !abort_maint && !abort_atomic |=> access_direction_bit == $past(abort_write))
        else $error("dir wrong");
    a_dir_atomic: assert property (tr && !abort_maint && abort_atomic && !abort_stage2
        |=> access_direction_bit != $past(abort_atomic_rd_fault))
        else $error("atomic dir wrong");
    a_align_code: assert property (abort_take && abort_class == 4'h8 && lv |=> fault_status_code == 6'h21)
        else $error("align code wrong");
    a_no_reserved: assert property (fault_status_code inside {[6'h00:6'h11], [6'h13:6'h18], [6'h1b:6'h1f], 6'h21,
        [6'h23:6'h29], 6'h2b, 6'h30, 6'h31, 6'h34, 6'h35})
        else $error("reserved code seen");
    a_reject_keep: assert property (abort_take && abort_class > 4'hc |=> encode_reject && $stable(syn))
        else $error("bad class kept");
    a_hold_fields: assert property (!abort_take |=> $stable(syn))
        else $error("syndrome moved");
endmodule
bind dse_syndrome dse_syndrome_checker i_chk (.*);

// [dse_sw_model.sv]
// software side: axi4-lite master
// bench reads its requests hierarchically
`timescale 1ns/1ps
module dse_sw_model (
    input wire logic clk, // core clock
    input wire logic awready, // address taken
    input wire logic wready, // data taken
    input wire logic bvalid, // response valid
    input wire logic [1:0] bresp, // write response
    input wire logic arready, // read address taken
    input wire logic rvalid, // read valid
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp // read response
);
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// [tb_data_abort_syndrome_encoder.sv]
// self-checking bench
// registers reached through the software model
`timescale 1ns/1ps
module tb_data_abort_syndrome_encoder;
    logic clk = 1'b0, resetn = 1'b0, take = 1'b0;
    logic [3:0] cls = 4'h0;
    logic [2:0] lvl = 3'h0;
    logic [6:0] fl = 7'h00;
    logic walk, dir, rej, vld, awr, wrd, bv, arr, rv;
    logic [5:0] code;
    logic [1:0] br, rr, resp;
    logic [31:0] rdt, d;
    int fail_count = 0, checked = 0, cyc = 0;
    dse_sw_model i_dse_sw_model (.clk(clk), .awready(awr), .wready(wrd), .bvalid(bv), .bresp(br),
        .arready(arr), .rvalid(rv), .rdata(rdt), .rresp(rr));
    dse_syndrome i_dse_syndrome (.clk(clk), .resetn(resetn), .s_axi_awaddr(i_dse_sw_model.awaddr),
        .s_axi_awvalid(i_dse_sw_model.awvalid), .s_axi_awready(awr), .s_axi_wdata(i_dse_sw_model.wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(i_dse_sw_model.wvalid), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(i_dse_sw_model.bready), .s_axi_araddr(i_dse_sw_model.araddr),
        .s_axi_arvalid(i_dse_sw_model.arvalid), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(i_dse_sw_model.rready), .abort_take(take), .abort_class(cls),
        .abort_on_walk(fl[6]), .abort_level(lvl), .abort_stage2(fl[5]), .abort_s1_walk(fl[4]),
        .abort_write(fl[3]), .abort_maint(fl[2]), .abort_atomic(fl[1]), .abort_atomic_rd_fault(fl[0]),
        .walk_origin_bit(walk), .access_direction_bit(dir), .fault_status_code(code),
        .syndrome_valid(vld), .encode_reject(rej));
    initial forever #20 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one abort pulse
    task automatic ab(input logic [3:0] c, input logic [2:0] l, input logic [6:0] f);
        @(posedge clk);
        take <= 1'b1;
        cls <= c;
        lvl <= l;
        fl <= f;
        @(posedge clk);
        take <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] syn();
        return {24'h0, walk, dir, code};
    endfunction
    task automatic ac(input logic [3:0] c, input logic [2:0] l, input logic [6:0] f, input logic [31:0] e);
        ab(c, l, f);
        chk(syn(), e);
    endtask
    task automatic t_levels();
        for (int l = 0; l < 4; l++) begin
            ac(4'h0, 3'(l), 7'h30, 32'h80 + l);
            ac(4'h1, 3'(l), 7'h24, 32'h44 + l);
        end
        ac(4'h1, 3'h0, 7'h10, 32'h04);
        chk({31'h0, vld}, 32'h1);
    endtask
    task automatic t_fixed();
        ac(4'h8, 3'h0, 7'h08, 32'h61);
        ac(4'h9, 3'h0, 7'h00, 32'h30);
        ac(4'ha, 3'h0, 7'h00, 32'h34);
        ac(4'h3, 3'h1, 7'h0b, 32'h0d);
        ac(4'h3, 3'h1, 7'h0a, 32'h4d);
        ac(4'h4, 3'h3, 7'h40, 32'h17);
        ac(4'h4, 3'h0, 7'h00, 32'h10);
        ac(4'h5, 3'h0, 7'h00, 32'h18);
    endtask
    task automatic t_reject();
        ab(4'h6, 3'h0, 7'h00);
        chk({31'h0, rej}, 32'h1);
        ac(4'h2, 3'h0, 7'h00, 32'h18);
        ac(4'hd, 3'h0, 7'h00, 32'h18);
        i_dse_sw_model.rd(8'h08, d, resp);
        chk(d, 32'h3);
    endtask
    task automatic t_opts();
        i_dse_sw_model.rd(8'h04, d, resp);
        chk(d, 32'h0);
        i_dse_sw_model.wr(8'h04, 32'h1b, resp);
        i_dse_sw_model.rd(8'h04, d, resp);
        chk(d, 32'h1b);
        ac(4'h6, 3'h0, 7'h00, 32'h11);
        ac(4'h2, 3'h0, 7'h00, 32'h08);
        ac(4'h1, 3'h7, 7'h00, 32'h2b);
        ac(4'h7, 3'h0, 7'h00, 32'h28);
        ac(4'h7, 3'h7, 7'h40, 32'h23);
        ac(4'hb, 3'h0, 7'h00, 32'h31);
        ac(4'hc, 3'h0, 7'h00, 32'h35);
        i_dse_sw_model.rd(8'h00, d, resp);
        chk(d, 32'h35);
        i_dse_sw_model.rd(8'h10, d, resp);
        chk({30'h0, resp}, 32'h2);
        i_dse_sw_model.wr(8'h04, 32'h3b, resp);
        ac(4'h3, 3'h1, 7'h3a, 32'h8d);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_levels();
        t_fixed();
        t_reject();
        t_opts();
        close_out();
    end
endmodule
